// [core/acp_pkg.sv]
// Constants shared by the configuration port and channel interface logic
`default_nettype none
package acp_pkg;
    // Clock and timing
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int FRAME_HZ = 8_000;
    localparam int MIN_BIT_HZ = 256_000;
    localparam int MAX_BIT_HZ = 4_096_000;
    localparam int MAX_LATENCY_US = 375;
    localparam int LATENCY_LIMIT_CYC = MAX_LATENCY_US * (SYS_CLK_HZ / 1_000_000);
    localparam logic [7:0] ALG_RST_CYCLES = 8'h10;
    // Channel indices, equal to the select bit values
    localparam int CHAN_Y = 0;
    localparam int CHAN_X = 1;
    // Address/command byte fields
    localparam int ACB_SEL_BIT = 6;
    localparam int ACB_ADDR_MSB = 5;
    // Channel control register fields and reset value
    localparam int CR_AS0 = 7;
    localparam int CR_AS1 = 6;
    localparam int CR_IPD = 5;
    localparam int CR_ALGORITHM_RESET_BIT = 4;
    localparam int CR_BYP = 3;
    localparam int CR_ULAW = 2;
    localparam int CR_AS2 = 1;
    localparam int CR_CPEX = 0;
    localparam logic [7:0] CTRL_RESET = 8'h20;
    localparam logic [5:0] SLOT_RESET = 6'h00;
    localparam logic [5:0] HW_SLOT = 6'h00;
    // Byte positions within one transaction
    localparam logic [2:0] BYTE_ACB = 3'h0;
    localparam logic [2:0] BYTE_CTRL = 3'h1;
    localparam logic [2:0] BYTE_ISLOT = 3'h2;
    localparam logic [2:0] BYTE_OSLOT = 3'h3;
    localparam logic [2:0] BYTE_EXTRA = 3'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Frame bit position width: 512 bits per frame at the top rate
    localparam int POS_W = 9;
    typedef enum logic [1:0] {CFG_IDLE, CFG_MATCH, CFG_SKIP} acp_cfg_state_t;
endpackage : acp_pkg
`default_nettype wire

// [core/acp_cfg_rx.sv]
// Serial configuration receiver running on the configuration clock
`default_nettype none
module acp_cfg_rx (
    input wire logic cfg_clk_i,
    input wire logic rst_i,
    input wire logic cfg_cs_n_i,
    input wire logic config_serial_in_i,
    output logic [7:0] byte_o,
    output logic [2:0] byte_idx_o,
    output logic byte_tog_o
);
    import acp_pkg::*;

    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [6:0] shift;

    // Counters cleared while deselected, so a partial byte is dropped
    always_ff @(posedge cfg_clk_i or posedge cfg_cs_n_i or posedge rst_i) begin
        if (rst_i || cfg_cs_n_i) begin
            bit_cnt <= 3'h0;
            byte_cnt <= BYTE_ACB;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST && byte_cnt != BYTE_EXTRA) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end

    // Least significant bit arrives first, taken on the rising edge
    always_ff @(posedge cfg_clk_i) begin
        shift <= {config_serial_in_i, shift[6:1]};
    end

    // Held word plus toggle; word stays put for a whole byte time
    always_ff @(posedge cfg_clk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_o <= 8'h00;
            byte_idx_o <= BYTE_ACB;
            byte_tog_o <= 1'b0;
        end else if (!cfg_cs_n_i && bit_cnt == BIT_LAST) begin
            byte_o <= {config_serial_in_i, shift};
            byte_idx_o <= byte_cnt;
            byte_tog_o <= ~byte_tog_o;
        end
    end
endmodule : acp_cfg_rx
`default_nettype wire

// [core/acp_core.sv]
// Configuration port, control registers and TDM channel interfaces
`default_nettype none
module acp_core (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic mode_select_pin_i,
    input wire logic [acp_pkg::ACB_ADDR_MSB:0] chan_addr_pin_i,
    input wire logic cfg_clk_i,
    input wire logic cfg_cs_n_i,
    input wire logic config_serial_in_i,
    input wire logic x_bit_clock_i,
    input wire logic y_bit_clock_i,
    input wire logic x_frame_sync_i,
    input wire logic y_frame_sync_i,
    input wire logic x_serial_in_i,
    input wire logic y_serial_in_i,
    input wire logic [7:0] x_engine_data_i,
    input wire logic [7:0] y_engine_data_i,
    output logic x_serial_out_o,
    output logic x_serial_out_oe_n_o,
    output logic y_serial_out_o,
    output logic y_serial_out_oe_n_o,
    output logic [7:0] x_sample_o,
    output logic [7:0] y_sample_o,
    output logic x_sample_valid_o,
    output logic y_sample_valid_o,
    output logic [7:0] x_ctrl_o,
    output logic [7:0] y_ctrl_o,
    output logic x_alg_reset_o,
    output logic y_alg_reset_o,
    output logic x_bypass_o,
    output logic y_bypass_o,
    output logic standby_o
);
    import acp_pkg::*;

    localparam int ALG_WAIT_MAX = 20;

    function automatic logic slot_hit(input logic [POS_W-1:0] pos, input logic [5:0] slot);
        slot_hit = (pos[POS_W-1:3] == slot);
    endfunction : slot_hit

    // Pin strapped control: coding, format, bypass; 32 kbit/s, enabled
    function automatic logic [7:0] hw_ctrl(input logic [2:0] pins);
        logic [7:0] v;
        v = 8'h00;
        v[CR_CPEX] = pins[0];
        v[CR_ULAW] = pins[1];
        v[CR_BYP] = pins[2];
        hw_ctrl = v;
    endfunction : hw_ctrl

    // Receiver on the configuration clock
    logic [7:0] rx_byte;
    logic [2:0] rx_idx;
    logic rx_tog;

    acp_cfg_rx u_rx (
        .cfg_clk_i(cfg_clk_i),
        .rst_i(rst_i),
        .cfg_cs_n_i(cfg_cs_n_i),
        .config_serial_in_i(config_serial_in_i),
        .byte_o(rx_byte),
        .byte_idx_o(rx_idx),
        .byte_tog_o(rx_tog)
    );

    // Three stage pin synchronisers; value taken once stages two and three agree, address pins excepted
    logic [10:0] pin_s1;
    logic [10:0] pin_s2;
    logic [10:0] pin_s3;
    logic [10:0] pin_f;
    logic [10:0] pin_d;
    logic tog_seen;

    always_ff @(posedge sys_clk_i) begin
        pin_s1 <= {rx_tog, cfg_cs_n_i, mode_select_pin_i, x_serial_in_i, y_serial_in_i,
                   x_frame_sync_i, y_frame_sync_i, x_bit_clock_i, y_bit_clock_i, 2'b00};
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        for (int i = 0; i < 11; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
                pin_f[i] <= pin_s3[i];
            end
        end
        pin_d <= pin_f;
    end

    logic [ACB_ADDR_MSB:0] addr_s1;
    logic [ACB_ADDR_MSB:0] addr_s2;
    logic [ACB_ADDR_MSB:0] addr_f;

    always_ff @(posedge sys_clk_i) begin
        addr_s1 <= chan_addr_pin_i;
        addr_s2 <= addr_s1;
        addr_f <= addr_s2;
    end

    logic tog_f;
    logic cs_n_f;
    logic mode_f;
    logic [1:0] din_f;
    logic [1:0] fs_f;
    logic [1:0] bclk_f;
    logic [1:0] bclk_d;
    assign tog_f = pin_f[10];
    assign cs_n_f = pin_f[9];
    assign mode_f = pin_f[8];
    assign din_f = pin_f[7:6];
    assign fs_f = pin_f[5:4];
    assign bclk_f = pin_f[3:2];
    assign bclk_d = pin_d[3:2];

    logic byte_evt;
    logic [1:0] rise;
    logic [1:0] fall;
    assign byte_evt = (tog_f != tog_seen);
    assign rise = bclk_f & ~bclk_d;
    assign fall = ~bclk_f & bclk_d;

    // Mode is a strap, caught while reset is held
    logic sw_mode;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sw_mode <= mode_f;
            tog_seen <= tog_f;
        end else begin
            tog_seen <= tog_f;
        end
    end

    // Transaction decode
    acp_cfg_state_t state;
    logic sel;
    logic busy;
    assign busy = (state == CFG_MATCH);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !sw_mode) begin
            state <= CFG_IDLE;
            sel <= 1'b0;
        end else begin
            case (state)
                CFG_IDLE: begin
                    if (byte_evt && rx_idx == BYTE_ACB) begin
                        sel <= rx_byte[ACB_SEL_BIT];
                        if (rx_byte[ACB_ADDR_MSB:0] == addr_f) begin
                            state <= CFG_MATCH;
                        end else begin
                            state <= CFG_SKIP;
                        end
                    end
                end
                CFG_MATCH, CFG_SKIP: begin
                    if (cs_n_f) begin
                        state <= CFG_IDLE;
                    end
                end
                default: state <= CFG_IDLE;
            endcase
        end
    end

    // Control and slot registers, per channel; index equals select bit
    logic [7:0] ctrl [2];
    logic [5:0] islot [2];
    logic [5:0] oslot [2];
    logic [7:0] alg_cnt [2];

    always_ff @(posedge sys_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (rst_i) begin
                ctrl[c] <= CTRL_RESET;
                islot[c] <= SLOT_RESET;
                oslot[c] <= SLOT_RESET;
                alg_cnt[c] <= 8'h00;
            end else if (!sw_mode) begin
                ctrl[c] <= hw_ctrl(c == CHAN_X ? addr_f[2:0] : addr_f[5:3]);
                islot[c] <= HW_SLOT;
                oslot[c] <= HW_SLOT;
                alg_cnt[c] <= 8'h00;
            end else begin
                alg_cnt[c] <= ctrl[c][CR_ALGORITHM_RESET_BIT] ? alg_cnt[c] + 8'h01 : 8'h00;
                if (ctrl[c][CR_ALGORITHM_RESET_BIT] && alg_cnt[c] == ALG_RST_CYCLES) begin
                    ctrl[c][CR_ALGORITHM_RESET_BIT] <= 1'b0;
                end
                // A host write after the self clear wins in the same cycle
                if (busy && byte_evt && sel == c[0]) begin
                    case (rx_idx)
                        BYTE_CTRL: ctrl[c] <= rx_byte;
                        BYTE_ISLOT: islot[c] <= rx_byte[5:0];
                        BYTE_OSLOT: oslot[c] <= rx_byte[5:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // Channel TDM interfaces on synchronised bit clocks
    logic [POS_W-1:0] pos [2];
    logic [7:0] in_shift [2];
    logic [7:0] sample [2];
    logic [7:0] out_shift [2];
    logic [1:0] sample_vld;
    logic [1:0] sdo;
    logic [1:0] sdo_oe_n;
    logic [1:0] bypass_bit;
    logic [1:0] alg_rst;
    logic stby;
    logic [POS_W-1:0] next_pos [2];
    logic [7:0] next_word [2];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            next_pos[c] = fs_f[c] ? '0 : pos[c];
            next_word[c] = bypass_bit[c] ? sample[c] : (c == CHAN_X ? x_engine_data_i : y_engine_data_i);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            sample_vld[c] <= 1'b0;
            if (rst_i) begin
                pos[c] <= '0;
                in_shift[c] <= 8'h00;
                sample[c] <= 8'h00;
            end else if (fall[c]) begin
                pos[c] <= next_pos[c] + 9'h001;
                if (!ctrl[c][CR_IPD] && slot_hit(next_pos[c], islot[c])) begin
                    in_shift[c] <= {in_shift[c][6:0], din_f[c]};
                    if (next_pos[c][2:0] == BIT_LAST) begin
                        sample[c] <= {in_shift[c][6:0], din_f[c]};
                        sample_vld[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Output word loaded at slot start; bypass returns within one frame
    always_ff @(posedge sys_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (rst_i) begin
                sdo[c] <= 1'b0;
                sdo_oe_n[c] <= 1'b1;
                out_shift[c] <= 8'h00;
            end else if (ctrl[c][CR_IPD] || busy) begin
                sdo_oe_n[c] <= 1'b1;
            end else if (rise[c]) begin
                sdo_oe_n[c] <= !slot_hit(pos[c], oslot[c]);
                if (slot_hit(pos[c], oslot[c])) begin
                    if (pos[c][2:0] == 3'h0) begin
                        out_shift[c] <= next_word[c];
                        sdo[c] <= next_word[c][7];
                    end else begin
                        sdo[c] <= out_shift[c][~pos[c][2:0]];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int c = 0; c < 2; c++) begin
            bypass_bit[c] <= !rst_i && ctrl[c][CR_BYP] && !ctrl[c][CR_IPD];
            alg_rst[c] <= !rst_i && ctrl[c][CR_ALGORITHM_RESET_BIT];
        end
        stby <= rst_i || (ctrl[0][CR_IPD] && ctrl[1][CR_IPD]);
    end

    assign x_serial_out_o = sdo[CHAN_X];
    assign y_serial_out_o = sdo[CHAN_Y];
    assign x_serial_out_oe_n_o = sdo_oe_n[CHAN_X];
    assign y_serial_out_oe_n_o = sdo_oe_n[CHAN_Y];
    assign x_sample_o = sample[CHAN_X];
    assign y_sample_o = sample[CHAN_Y];
    assign x_sample_valid_o = sample_vld[CHAN_X];
    assign y_sample_valid_o = sample_vld[CHAN_Y];
    assign x_ctrl_o = ctrl[CHAN_X];
    assign y_ctrl_o = ctrl[CHAN_Y];
    assign x_alg_reset_o = alg_rst[CHAN_X];
    assign y_alg_reset_o = alg_rst[CHAN_Y];
    assign x_bypass_o = bypass_bit[CHAN_X];
    assign y_bypass_o = bypass_bit[CHAN_Y];
    assign standby_o = stby;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_reset_ctrl_value: assert property ($past(rst_i) |-> x_ctrl_o == CTRL_RESET
        && y_ctrl_o == CTRL_RESET && standby_o)
        else $error("control not at reset value after reset");
    a_idle_floats_out: assert property (ctrl[CHAN_X][CR_IPD] |=> x_serial_out_oe_n_o)
        else $error("idle channel X drives its output");
    a_update_floats_out: assert property (busy |=> x_serial_out_oe_n_o
        && y_serial_out_oe_n_o)
        else $error("output driven during register update");
    a_standby_both_idle: assert property ((ctrl[0][CR_IPD] && ctrl[1][CR_IPD])
        |=> standby_o)
        else $error("standby missing with both channels idle");
    a_algorithm_reset_bit_self_clear: assert property ($rose(ctrl[CHAN_X][CR_ALGORITHM_RESET_BIT]) |->
        ##[1:ALG_WAIT_MAX] !ctrl[CHAN_X][CR_ALGORITHM_RESET_BIT])
        else $error("algorithm reset bit not cleared");
    a_hw_slots_zero: assert property (!sw_mode && !$past(sw_mode) |->
        islot[0] == HW_SLOT && oslot[1] == HW_SLOT && state == CFG_IDLE)
        else $error("hardware mode slot or port not idle");
    a_bypass_gating: assert property (x_bypass_o == $past(ctrl[CHAN_X][CR_BYP]
        && !ctrl[CHAN_X][CR_IPD]))
        else $error("bypass flag does not follow bypass and idle bits");
    a_addr_mismatch_skip: assert property (state == CFG_IDLE && byte_evt && sw_mode
        && rx_idx == BYTE_ACB && rx_byte[ACB_ADDR_MSB:0] != addr_f |=> state == CFG_SKIP)
        else $error("mismatched address not skipped");
    a_out_on_rise: assert property ($changed(x_serial_out_o) |-> $past(rise[CHAN_X]))
        else $error("serial output changed away from a rising bit clock");
    a_sample_on_fall: assert property (x_sample_valid_o |-> $past(fall[CHAN_X]))
        else $error("sample taken away from a falling bit clock");
endmodule : acp_core
`default_nettype wire

// [testbench/acp_tdm_partner.sv]
// Backplane codec model for one channel: bit clock, frame sync, slot data
`default_nettype none
module acp_tdm_partner #(
    parameter int HALF_NS = 123,
    parameter int IN_SLOT = 0,
    parameter int OUT_SLOT = 1,
    parameter logic [7:0] TX_WORD = 8'hA5
) (
    output logic bclk_o,
    output logic fs_o,
    output logic sd_o,
    input wire logic sd_i,
    input wire logic oe_n_i,
    output logic [7:0] rx_word_o,
    output logic [15:0] rx_cnt_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NBITS = 125_000 / (2 * HALF_NS);
    logic [7:0] shift;
    initial begin
        bclk_o = 1'b0;
        fs_o = 1'b0;
        sd_o = 1'b0;
        shift = 8'h00;
        rx_word_o = 8'h00;
        rx_cnt_o = 16'h0000;
        // Offset keeps our edges off the system clock edges
        #0.3;
        forever begin
            for (int p = 0; p < NBITS; p++) begin
                #HALF_NS;
                bclk_o = 1'b1;
                fs_o = (p == 0);
                // Outside our slot the line is not ours: keep it moving
                sd_o = (p / 8 == IN_SLOT) ? TX_WORD[7 - p % 8] : ~sd_o;
                #HALF_NS;
                bclk_o = 1'b0;
                if (p / 8 == OUT_SLOT && oe_n_i == 1'b0) begin
                    shift = {shift[6:0], sd_i};
                    if (p % 8 == 7) begin
                        rx_word_o = shift;
                        rx_cnt_o++;
                    end
                end
            end
        end
    end
endmodule : acp_tdm_partner
`default_nettype wire

// [testbench/adpcm_config_port_and_tdm_control_test.sv]
// Testbench for the configuration port and channel interfaces
`default_nettype none
module adpcm_config_port_and_tdm_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    import acp_pkg::*;
    localparam logic [7:0] ACB_X = 8'h6A;
    localparam logic [7:0] ACB_Y = 8'h2A;
    localparam logic [7:0] X_TX = 8'hA5;
    localparam logic [7:0] Y_TX = 8'hC3;
    localparam int FAST_HALF = 80;
    // Standby caps the port near 39 kHz, so this is slow
    localparam int SLOW_HALF = 12_900;
    logic sys_clk, rst, mode, cfg_clk, cs_n, config_serial_in;
    logic [5:0] addr;
    logic xbclk, ybclk, xfs, yfs, x_serial_in, y_serial_in, x_serial_out, xoe_n, y_serial_out, yoe_n;
    logic [7:0] x_eng, y_eng, x_smp, y_smp, x_ctrl, y_ctrl, x_rx, y_rx;
    logic x_sv, y_sv, x_ar, y_ar, x_byp, y_byp, standby;
    logic [15:0] x_cnt, y_cnt;
    int failures = 0;
    int samples_checked = 0;
    int alg_cyc = 0;

    acp_core dut (.sys_clk_i(sys_clk), .rst_i(rst), .mode_select_pin_i(mode),
        .chan_addr_pin_i(addr), .cfg_clk_i(cfg_clk), .cfg_cs_n_i(cs_n),
        .config_serial_in_i(config_serial_in), .x_bit_clock_i(xbclk), .y_bit_clock_i(ybclk),
        .x_frame_sync_i(xfs), .y_frame_sync_i(yfs), .x_serial_in_i(x_serial_in), .y_serial_in_i(y_serial_in),
        .x_engine_data_i(x_eng), .y_engine_data_i(y_eng), .x_serial_out_o(x_serial_out),
        .x_serial_out_oe_n_o(xoe_n), .y_serial_out_o(y_serial_out), .y_serial_out_oe_n_o(yoe_n),
        .x_sample_o(x_smp), .y_sample_o(y_smp), .x_sample_valid_o(x_sv),
        .y_sample_valid_o(y_sv), .x_ctrl_o(x_ctrl), .y_ctrl_o(y_ctrl), .x_alg_reset_o(x_ar),
        .y_alg_reset_o(y_ar), .x_bypass_o(x_byp), .y_bypass_o(y_byp), .standby_o(standby));
    acp_tdm_partner #(.HALF_NS(123), .IN_SLOT(2), .OUT_SLOT(5), .TX_WORD(X_TX)) px (
        .bclk_o(xbclk), .fs_o(xfs), .sd_o(x_serial_in), .sd_i(x_serial_out), .oe_n_i(xoe_n),
        .rx_word_o(x_rx), .rx_cnt_o(x_cnt));
    acp_tdm_partner #(.HALF_NS(247), .IN_SLOT(0), .OUT_SLOT(1), .TX_WORD(Y_TX)) py (
        .bclk_o(ybclk), .fs_o(yfs), .sd_o(y_serial_in), .sd_i(y_serial_out), .oe_n_i(yoe_n),
        .rx_word_o(y_rx), .rx_cnt_o(y_cnt));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (x_ar === 1'b1) begin
            alg_cyc++;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : do_reset

    // Bits go out from bit 0 upward: first byte first, each lsb first
    task automatic cfg_wr(input logic [31:0] data, input int nbits, input int half,
            input bit hold);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #3;
        for (int i = 0; i < nbits; i++) begin
            config_serial_in = data[i];
            #(half);
            cfg_clk = 1'b1;
            #(half);
            cfg_clk = 1'b0;
        end
        if (hold) begin
            repeat (10) @(posedge sys_clk);
            chk({6'h00, xoe_n, yoe_n}, 8'h03);
        end
        @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
    endtask : cfg_wr

    task automatic t_reset();
        chk(x_ctrl, CTRL_RESET);
        chk(y_ctrl, CTRL_RESET);
        chk({3'h0, standby, xoe_n, yoe_n, x_byp, y_ar}, 8'h1C);
    endtask : t_reset

    task automatic t_config();
        cfg_wr({16'h0000, 8'h00, ACB_X}, 16, SLOW_HALF, 1'b0);
        chk(x_ctrl, 8'h00);
        chk(y_ctrl, CTRL_RESET);
        chk({7'h00, standby}, 8'h00);
        cfg_wr({8'h01, 8'h00, 8'h08, ACB_Y}, 32, FAST_HALF, 1'b0);
        chk(y_ctrl, 8'h08);
        chk({6'h00, y_byp, standby}, 8'h02);
        cfg_wr({16'h0000, 8'h20, ACB_X ^ 8'h01}, 16, FAST_HALF, 1'b0);
        chk(x_ctrl, 8'h00);
        // A stray partial byte must not shift the next transaction
        cfg_wr(32'hFFFF_FFFF, 5, FAST_HALF, 1'b0);
        cfg_wr({8'h05, 8'h02, 8'h00, ACB_X}, 32, FAST_HALF, 1'b0);
    endtask : t_config

    task automatic t_tdm();
        // New engine word, distinct from both the input word and the old one
        x_eng <= x_eng ^ 8'h0F;
        repeat (26000) @(posedge sys_clk);
        chk(x_smp, X_TX);
        chk(y_smp, Y_TX);
        chk(x_rx, 8'h55);
        chk(y_rx, Y_TX);
    endtask : t_tdm

    task automatic t_algrst();
        int cyc0;
        cyc0 = alg_cyc;
        cfg_wr({16'h0000, 8'h10, ACB_X}, 16, FAST_HALF, 1'b0);
        repeat (30) @(posedge sys_clk);
        cyc0 = alg_cyc - cyc0;
        chk({7'h00, cyc0 >= ALG_RST_CYCLES && cyc0 <= ALG_RST_CYCLES + 2}, 8'h01);
        chk(x_ctrl, 8'h00);
    endtask : t_algrst

    task automatic t_idle();
        logic [15:0] xc, yc;
        cfg_wr({16'h0000, 8'h20, ACB_X}, 16, FAST_HALF, 1'b1);
        xc = x_cnt;
        yc = y_cnt;
        repeat (13000) @(posedge sys_clk);
        chk(x_cnt[7:0], xc[7:0]);
        chk({6'h00, xoe_n, y_cnt != yc}, 8'h03);
    endtask : t_idle

    task automatic t_hw();
        mode <= 1'b0;
        addr <= 6'h1D;
        do_reset();
        chk(x_ctrl, 8'h09);
        chk(y_ctrl, 8'h05);
        cfg_wr({16'h0000, 8'h20, 8'h5D}, 16, FAST_HALF, 1'b0);
        chk(x_ctrl, 8'h09);
    endtask : t_hw

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        #950_000;
        failures++;
        conclude();
    end

    initial begin
        sys_clk = 1'b0;
        // Deferred so the receiver's asynchronous clear sees a real edge
        rst <= 1'b1;
        mode = 1'b1;
        addr = 6'h2A;
        cfg_clk = 1'b0;
        cs_n <= 1'b1;
        config_serial_in = 1'b0;
        x_eng = 8'h5A;
        y_eng = 8'h3C;
        do_reset();
        t_reset();
        t_config();
        t_tdm();
        t_algrst();
        t_idle();
        t_hw();
        conclude();
    end
endmodule : adpcm_config_port_and_tdm_control_test
`default_nettype wire
